/* core/cc_ctrl.sv */
// How it works
// RULE_01: a bit is one sync quantum, then prop+phase1 quanta, then phase2 quanta.
// RULE_02: quantum length is the clock divided by the programmable quantum divisor.
// RULE_03: prop_phase1, phase2 and jump width are separate fields counted in quanta.
// RULE_04: software reads the timing fields and divisor back exactly as written.
// RULE_05: software picks the closest rate not above the request.
// RULE_06: software keeps old timing and reports zero for an impossible rate.
// RULE_07: while disabled no bus traffic is processed.
// RULE_08: disable keeps controller state and object contents intact.
// RULE_09: once enabled pending frames are sent and received frames processed.
// RULE_10: after reset the controller is disabled; object memory is undefined.
// RULE_11: software clears every object before the first enable.
// RULE_12: software initialises and sets bit timing before enabling.
// RULE_13: error counter register holds rx, tx counts and error-passive flag.
// RULE_14: interrupt clear names status id or object 1..32, clears only that.
// RULE_15: reading the status register clears the pending status interrupt.
// RULE_16: reading an object clears that object's pending interrupt.
// RULE_17: software clears sources early since clears take cycles.
// RULE_18: cause register shows status id or highest-priority pending object 1..32.
// RULE_19: lower-numbered objects win for transmit order and interrupt reporting.
// RULE_20: irq stays high while any enabled source pends, drops when all clear.
//
// Added by the designer: the placing of the registers and the APB register port.
`default_nettype none
`include "cc_defines.svh"
module cc_ctrl
  import cc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // bus pin
  input  wire logic        can_rx_pin,
  // protocol engine events, same clock
  input  wire logic        eng_tx_done,
  input  wire logic        eng_tx_err,
  input  wire logic        eng_rx_valid,
  input  wire logic [4:0]  eng_rx_obj,
  input  wire logic [31:0] eng_rx_data,
  input  wire logic        eng_rx_err,
  // to protocol engine
  output logic             bus_active,
  output logic             tx_req_valid,
  output logic [4:0]       tx_req_obj,
  output logic [31:0]      tx_req_data,
  output logic             quantum_tick,
  output logic             sample_tick,
  output logic             bit_tick,
  output logic             rx_bit,
  output logic [1:0]       sync_jump_width,
  // interrupt
  output logic             irq
);
  cc_mem_if mif ();
  cc_objmem u_mem (.pclk(pclk), .mp(mif.mem));

  logic        en_r;
  logic [31:0] bittim_r;
  logic [1:0]  inten_r;
  cc_obj_idx_t objsel_r;
  logic [31:0] txpend_r, objpend_r;
  logic        stat_pend_r, st_tx_r, st_rx_r, st_err_r;
  logic [7:0]  tx_cnt_r, rx_cnt_r;
  logic        ack_r;
  logic [31:0] prdata_r;
  logic        rx_s1_r, rx_s2_r;
  logic [7:0]  presc_r;
  logic [3:0]  qcnt_r;
  cc_seg_t     seg_r, seg_nxt;
  logic        txv_r;
  cc_obj_idx_t txo_r;

  // apb decode; one wait state so read data comes from a flop
  logic wr_go, rd_go, hit, first_acc;
  assign first_acc = psel && penable && !ack_r;
  assign wr_go = psel && penable && ack_r && pwrite;
  assign rd_go = psel && penable && ack_r && !pwrite;
  assign pready = ack_r;
  assign prdata = prdata_r;
  always_comb begin
    case (paddr)
      `CC_OFF_CTL, `CC_OFF_BITTIM, `CC_OFF_ERRCNT, `CC_OFF_STATUS, `CC_OFF_CAUSE,
      `CC_OFF_PEND, `CC_OFF_INTCLR, `CC_OFF_INTEN, `CC_OFF_OBJSEL, `CC_OFF_OBJDATA,
      `CC_OFF_TXREQ: hit = 1'b1;
      default:       hit = 1'b0;
    endcase
  end
  assign pslverr = ack_r && psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= first_acc;
    end
  end

  // derived timing fields, zero treated as one
  logic [7:0] qdiv;
  logic [3:0] pp1;
  logic [2:0] ph2;
  assign qdiv = (bittim_r[`CC_BT_QDIV] == 8'h00) ? `CC_ONE8 : bittim_r[`CC_BT_QDIV]; // RULE_02
  assign pp1  = (bittim_r[`CC_BT_PP1] == 4'h0) ? `CC_ONE4 : bittim_r[`CC_BT_PP1];
  assign ph2  = (bittim_r[`CC_BT_PH2] == 3'h0) ? `CC_ONE3 : bittim_r[`CC_BT_PH2];
  assign sync_jump_width = bittim_r[`CC_BT_SJW]; // RULE_03

  // highest-priority pending object: lowest index wins
  logic        obj_any;
  cc_obj_idx_t obj_top, tx_top;
  always_comb begin
    obj_top = '0;
    tx_top  = '0;
    for (int i = `CC_NUM_OBJ - 1; i >= 0; i--) begin
      if (objpend_r[i]) obj_top = 5'(i); // RULE_19
      if (txpend_r[i])  tx_top  = 5'(i); // RULE_19
    end
  end
  assign obj_any = |objpend_r;

  // cause value: status first, then object number 1..32, else zero
  logic [31:0] cause;
  always_comb begin
    if (stat_pend_r)  cause = `CC_STATUS_CODE; // RULE_18
    else if (obj_any) cause = {26'h0, 6'(obj_top) + 6'h01}; // RULE_18
    else              cause = 32'h0000_0000;
  end

  // read mux, registered in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce && first_acc) begin
      case (paddr)
        `CC_OFF_CTL:     prdata_r <= {31'h0, en_r};
        `CC_OFF_BITTIM:  prdata_r <= bittim_r; // RULE_04
        `CC_OFF_ERRCNT:  prdata_r <= {15'h0, (rx_cnt_r >= `CC_ERR_PASSIVE), rx_cnt_r,
                                      tx_cnt_r}; // RULE_13
        `CC_OFF_STATUS:  prdata_r <= {27'h0, st_err_r, st_rx_r, st_tx_r,
                                      (rx_cnt_r >= `CC_ERR_PASSIVE), en_r};
        `CC_OFF_CAUSE:   prdata_r <= cause;
        `CC_OFF_PEND:    prdata_r <= objpend_r;
        `CC_OFF_INTEN:   prdata_r <= {30'h0, inten_r};
        `CC_OFF_OBJSEL:  prdata_r <= {27'h0, objsel_r};
        `CC_OFF_OBJDATA: prdata_r <= mif.rdata_a;
        `CC_OFF_TXREQ:   prdata_r <= txpend_r;
        default:         prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // control and configuration; disable clears only the prescaler, segment sequencer and transmit offer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r     <= 1'b0; // RULE_10
      bittim_r <= `CC_BITTIM_RST;
      inten_r  <= `CC_INTEN_RST;
      objsel_r <= '0;
    end else if (ce && wr_go) begin
      case (paddr)
        `CC_OFF_CTL:    en_r     <= pwdata[`CC_CTL_EN]; // RULE_08
        `CC_OFF_BITTIM: bittim_r <= pwdata & `CC_BT_MASK; // RULE_03
        `CC_OFF_INTEN:  inten_r  <= pwdata[1:0];
        `CC_OFF_OBJSEL: objsel_r <= pwdata[4:0];
        default:        ;
      endcase
    end
  end

  // events count only while the controller is on the bus
  logic rx_evt, txd_evt, txe_evt, rxe_evt;
  assign rx_evt  = en_r && eng_rx_valid; // RULE_07
  assign txd_evt = en_r && eng_tx_done;
  assign txe_evt = en_r && eng_tx_err;
  assign rxe_evt = en_r && eng_rx_err;
  assign bus_active = en_r;

  // object memory: host writes win, engine writes received data otherwise
  logic host_mw;
  assign host_mw      = wr_go && (paddr == `CC_OFF_OBJDATA);
  assign mif.ce       = ce;
  assign mif.we       = host_mw || rx_evt; // RULE_09
  assign mif.waddr    = host_mw ? objsel_r : eng_rx_obj;
  assign mif.wdata    = host_mw ? pwdata : eng_rx_data;
  assign mif.raddr_a  = objsel_r;
  assign mif.raddr_b  = tx_top;

  // per-object pending transmit and interrupt flags; set beats clear
  logic clr_hit_obj, clr_hit_stat, obj_rd;
  assign clr_hit_obj  = wr_go && (paddr == `CC_OFF_INTCLR) && (pwdata[31:6] == 26'h0)
                        && (pwdata[5:0] != 6'h00) && (pwdata[5:0] <= 6'd32); // RULE_14
  assign clr_hit_stat = wr_go && (paddr == `CC_OFF_INTCLR) && (pwdata == `CC_STATUS_CODE);
  assign obj_rd       = rd_go && (paddr == `CC_OFF_OBJDATA);
  genvar g;
  generate
    for (g = 0; g < `CC_NUM_OBJ; g++) begin : g_obj
      logic set_i, txdone_i, clr_i, txset_i;
      assign txdone_i = txd_evt && txv_r && (txo_r == 5'(g));
      assign set_i    = txdone_i || (rx_evt && (eng_rx_obj == 5'(g)));
      assign clr_i    = (clr_hit_obj && (pwdata[5:0] == 6'(g + 1))) // RULE_14
                        || (obj_rd && (objsel_r == 5'(g))); // RULE_16
      assign txset_i  = wr_go && (paddr == `CC_OFF_TXREQ) && pwdata[g];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          objpend_r[g] <= 1'b0;
          txpend_r[g]  <= 1'b0;
        end else if (ce) begin
          if (set_i) objpend_r[g] <= 1'b1;
          else if (clr_i) objpend_r[g] <= 1'b0;
          if (txset_i) txpend_r[g] <= 1'b1;
          else if (txdone_i) txpend_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // transmit request: one cycle behind choice so data and number line up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txv_r <= 1'b0;
      txo_r <= '0;
    end else if (ce) begin
      txv_r <= en_r && (|txpend_r) && !(txd_evt && txv_r); // RULE_09
      txo_r <= tx_top; // RULE_19
    end
  end
  assign tx_req_valid = txv_r && en_r; // RULE_07 offer drops with enable, not a cycle later
  assign tx_req_obj   = txo_r;
  assign tx_req_data  = mif.rdata_b;

  // status flags and status interrupt; read of status clears them
  logic st_rd, st_evt;
  assign st_rd  = rd_go && (paddr == `CC_OFF_STATUS);
  assign st_evt = txd_evt || rx_evt || txe_evt || rxe_evt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_pend_r <= 1'b0;
      st_tx_r     <= 1'b0;
      st_rx_r     <= 1'b0;
      st_err_r    <= 1'b0;
    end else if (ce) begin
      stat_pend_r <= st_evt || (stat_pend_r && !st_rd && !clr_hit_stat); // RULE_15
      st_tx_r     <= txd_evt || (st_tx_r && !st_rd);
      st_rx_r     <= rx_evt || (st_rx_r && !st_rd);
      st_err_r    <= txe_evt || rxe_evt || (st_err_r && !st_rd);
    end
  end

  // error counters, saturating: tx steps up by eight, rx by one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_r <= 8'h00;
      rx_cnt_r <= 8'h00;
    end else if (ce) begin
      if (txe_evt) begin
        tx_cnt_r <= (tx_cnt_r > (`CC_ERR_MAX - `CC_TX_ERR_STEP)) ? `CC_ERR_MAX
                    : tx_cnt_r + `CC_TX_ERR_STEP; // RULE_13
      end else if (txd_evt && tx_cnt_r != 8'h00) begin
        tx_cnt_r <= tx_cnt_r - `CC_ONE8;
      end
      if (rxe_evt) begin
        rx_cnt_r <= (rx_cnt_r == `CC_ERR_MAX) ? `CC_ERR_MAX : rx_cnt_r + `CC_ONE8; // RULE_13
      end else if (rx_evt && rx_cnt_r != 8'h00) begin
        rx_cnt_r <= rx_cnt_r - `CC_ONE8;
      end
    end
  end

  // interrupt line: level, follows pending sources
  assign irq = inten_r[`CC_IE_MASTER]
               && ((inten_r[`CC_IE_STATUS] && stat_pend_r) || obj_any); // RULE_20

  // pin synchroniser; only the second stage is looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else if (ce) begin
      rx_s1_r <= can_rx_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  // quantum prescaler; held at zero while disabled so a bit starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= 8'h00;
    end else if (ce) begin
      if (!en_r || quantum_tick) presc_r <= 8'h00; // RULE_07
      else presc_r <= presc_r + `CC_ONE8;
    end
  end
  assign quantum_tick = en_r && (presc_r == (qdiv - `CC_ONE8)); // RULE_02

  // segment sequencer inside one bit
  logic seg_end;
  always_comb begin
    seg_nxt = seg_r;
    seg_end = 1'b0;
    case (seg_r)
      CC_SEG_SYNC: begin
        seg_end = 1'b1; // RULE_01
        seg_nxt = CC_SEG_TSEG1;
      end
      CC_SEG_TSEG1: begin
        seg_end = (qcnt_r == pp1 - `CC_ONE4);
        if (seg_end) seg_nxt = CC_SEG_TSEG2;
      end
      CC_SEG_TSEG2: begin
        seg_end = (qcnt_r == {1'b0, ph2 - `CC_ONE3});
        if (seg_end) seg_nxt = CC_SEG_SYNC;
      end
      default: begin
        seg_nxt = CC_SEG_SYNC;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_r  <= CC_SEG_SYNC;
      qcnt_r <= 4'h0;
    end else if (ce) begin
      if (!en_r) begin
        seg_r  <= CC_SEG_SYNC;
        qcnt_r <= 4'h0;
      end else if (quantum_tick) begin
        seg_r  <= seg_nxt; // RULE_01
        qcnt_r <= seg_end ? 4'h0 : qcnt_r + `CC_ONE4;
      end
    end
  end
  assign sample_tick = quantum_tick && (seg_r == CC_SEG_TSEG1) && seg_end;
  assign bit_tick    = quantum_tick && (seg_r == CC_SEG_TSEG2) && seg_end;

  // bus level taken at the sample point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bit <= 1'b1;
    end else if (ce && sample_tick) begin
      rx_bit <= rx_s2_r;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);
  a_apb_wait_one: assert property (first_acc |=> pready) // RULE_04
    else $error("apb wait state not one cycle");
  a_bittim_rdback: assert property (wr_go && paddr == `CC_OFF_BITTIM
      |=> bittim_r == ($past(pwdata) & `CC_BT_MASK)) // RULE_04
    else $error("bit timing readback differs");
  a_disabled_quiet: assert property (!en_r |-> !tx_req_valid && !bit_tick && !quantum_tick) // RULE_07
    else $error("activity while disabled");
  a_irq_follows: assert property (irq |-> stat_pend_r || obj_any) // RULE_20
    else $error("irq without pending source");
  a_irq_drops: assert property (inten_r == 2'h3 && !stat_pend_r && !obj_any |-> !irq) // RULE_20
    else $error("irq with nothing pending");
  a_clr_obj: assert property (clr_hit_obj && !rx_evt && !txd_evt
      |=> !objpend_r[5'($past(pwdata[5:0]) - 6'h01)]) // RULE_14
    else $error("object clear not taken");
  a_stat_rdclr: assert property (st_rd && !st_evt |=> !stat_pend_r) // RULE_15
    else $error("status read did not clear");
  a_obj_rdclr: assert property (obj_rd && !rx_evt && !txd_evt |=> !objpend_r[$past(objsel_r)]) // RULE_16
    else $error("object read did not clear");
  a_cause_prio: assert property (!stat_pend_r && obj_any
      |-> objpend_r[obj_top] && ((objpend_r & ((32'h1 << obj_top) - 32'h1)) == 32'h0)) // RULE_19
    else $error("cause not lowest pending object");
  a_passive_rise: assert property ($rose(rx_cnt_r >= `CC_ERR_PASSIVE)
      |-> $past(rx_cnt_r) == 8'h7F) // RULE_13
    else $error("passive flag jumped");
  a_bit_sample: assert property (sample_tick |-> !bit_tick ##1 seg_r == CC_SEG_TSEG2) // RULE_01
    else $error("sample point out of order");
  c_bit_done: cover property (bit_tick);
  c_tx_done: cover property (tx_req_valid ##[1:20] eng_tx_done);
  c_irq_clear: cover property (irq ##1 !irq);
endmodule : cc_ctrl
`default_nettype wire

/* core/cc_defines.svh */
`ifndef CC_DEFINES_SVH
`define CC_DEFINES_SVH
// register byte offsets
`define CC_OFF_CTL      8'h00
`define CC_OFF_BITTIM   8'h04
`define CC_OFF_ERRCNT   8'h08
`define CC_OFF_STATUS   8'h0C
`define CC_OFF_CAUSE    8'h10
`define CC_OFF_PEND     8'h14
`define CC_OFF_INTCLR   8'h18
`define CC_OFF_INTEN    8'h1C
`define CC_OFF_OBJSEL   8'h20
`define CC_OFF_OBJDATA  8'h24
`define CC_OFF_TXREQ    8'h28
// field positions
`define CC_CTL_EN       0
`define CC_BT_QDIV      7:0
`define CC_BT_PP1       11:8
`define CC_BT_PH2       14:12
`define CC_BT_SJW       17:16
`define CC_BT_MASK      32'h0003_7FFF
`define CC_ERR_TX       7:0
`define CC_ERR_RX       15:8
`define CC_ERR_RP       16
`define CC_IE_MASTER    0
`define CC_IE_STATUS    1
// reset values
`define CC_BITTIM_RST   32'h0000_1401
`define CC_INTEN_RST    2'h0
// constants
`define CC_STATUS_ID    6'h20
`define CC_STATUS_CODE  32'h0000_8000
`define CC_NUM_OBJ      32
`define CC_ERR_PASSIVE  8'h80
`define CC_ERR_MAX      8'hFF
`define CC_TX_ERR_STEP  8'h08
`define CC_ONE8         8'h01
`define CC_ONE4         4'h1
`define CC_ONE3         3'h1
`endif

/* core/cc_mem_if.sv */
`default_nettype none
interface cc_mem_if;
  import cc_pkg::*;
  logic        ce;
  logic        we;
  cc_obj_idx_t waddr;
  cc_word_t    wdata;
  cc_obj_idx_t raddr_a;
  cc_word_t    rdata_a;
  cc_obj_idx_t raddr_b;
  cc_word_t    rdata_b;
  modport ctl (output ce, we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
  modport mem (input ce, we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
endinterface : cc_mem_if
`default_nettype wire

/* core/cc_objmem.sv */
`default_nettype none
module cc_objmem
  import cc_pkg::*;
(
  // clock
  input wire logic pclk,
  // ports
  cc_mem_if.mem    mp
);
  // no reset: object contents are undefined until software clears them
  cc_word_t mem_r [`CC_NUM_OBJ];

  // single write port
  always_ff @(posedge pclk) begin
    if (mp.ce && mp.we) begin
      mem_r[mp.waddr] <= mp.wdata;
    end
  end

  // two registered read ports: host and protocol engine
  always_ff @(posedge pclk) begin
    if (mp.ce) begin
      mp.rdata_a <= mem_r[mp.raddr_a];
      mp.rdata_b <= mem_r[mp.raddr_b];
    end
  end
endmodule : cc_objmem
`default_nettype wire

/* core/cc_pkg.sv */
`default_nettype none
package cc_pkg;
  // position inside one nominal bit
  typedef enum logic [1:0] {
    CC_SEG_SYNC  = 2'b00,
    CC_SEG_TSEG1 = 2'b01,
    CC_SEG_TSEG2 = 2'b10
  } cc_seg_t;
  typedef logic [4:0]  cc_obj_idx_t;
  typedef logic [31:0] cc_word_t;
endpackage : cc_pkg
`default_nettype wire

/* dv/can_controller_timing_and_control_bench.sv */
`default_nettype none
`include "cc_defines.svh"
module can_controller_timing_and_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset, apb
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er, seen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  // pin and engine side
  logic        can_rx_pin, tx_done, tx_err, rx_valid, rx_err, bus_active, tx_req_valid;
  logic        quantum_tick, sample_tick, bit_tick, rx_bit, irq;
  logic [4:0]  rx_obj, tx_req_obj;
  logic [31:0] rx_data, tx_req_data;
  logic [1:0]  sync_jump_width;
  int          fails = 0;
  int          checks = 0;

  cc_ctrl u_cc_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .can_rx_pin(can_rx_pin), .eng_tx_done(tx_done),
    .eng_tx_err(tx_err), .eng_rx_valid(rx_valid), .eng_rx_obj(rx_obj),
    .eng_rx_data(rx_data), .eng_rx_err(rx_err), .bus_active(bus_active),
    .tx_req_valid(tx_req_valid), .tx_req_obj(tx_req_obj), .tx_req_data(tx_req_data),
    .quantum_tick(quantum_tick), .sample_tick(sample_tick), .bit_tick(bit_tick),
    .rx_bit(rx_bit), .sync_jump_width(sync_jump_width), .irq(irq));

  cc_eng_model u_cc_eng_model (.pclk(pclk), .tx_req_valid(tx_req_valid),
    .tx_req_obj(tx_req_obj), .tx_req_data(tx_req_data), .eng_tx_done(tx_done),
    .eng_tx_err(tx_err), .eng_rx_valid(rx_valid), .eng_rx_obj(rx_obj),
    .eng_rx_data(rx_data), .eng_rx_err(rx_err));

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      test_done;
    end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask : rdc

  task tend(input string name);
    $display("test %s finished", name);
  endtask : tend

  // bounded wait for the far side to have sent n frames
  task wait_tx(input int n);
    int k;
    k = 0;
    while (u_cc_eng_model.tx_cnt < n && k < 300) begin
      @(posedge pclk);
      k++;
    end
    cmp(u_cc_eng_model.tx_cnt, n);
    if (k == 300) test_done;
  endtask : wait_tx

  // program timing while disabled, then time one whole bit
  task tmeas(input logic [31:0] bt, input logic pin, input int es, input int eb, input int eq);
    int k, s, b, q;
    wr(`CC_OFF_CTL, 32'h0);
    wr(`CC_OFF_BITTIM, bt);
    wr(`CC_OFF_CTL, 32'h1);
    can_rx_pin <= pin;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (bit_tick !== 1'b1 && k < 200);
    if (bit_tick !== 1'b1) begin
      fails++;
      test_done;
    end
    s = 0;
    b = 0;
    q = 0;
    for (k = 1; k <= 40 && b == 0; k++) begin
      @(posedge pclk);
      if (quantum_tick === 1'b1) q++;
      if (sample_tick === 1'b1 && s == 0) s = k;
      if (bit_tick === 1'b1) b = k;
    end
    cmp(s, es);
    cmp(b, eb);
    cmp(q, eq);
    cmp(rx_bit, pin);
  endtask : tmeas

  initial begin
    {presetn, ce, psel, penable, pwrite} = 5'b01000;
    paddr = 8'h00;
    pwdata = 32'h0;
    can_rx_pin = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cmp(bus_active, 1'b0);
    rdc(`CC_OFF_CTL, 32'h0);
    rdc(`CC_OFF_BITTIM, `CC_BITTIM_RST);
    rdc(`CC_OFF_ERRCNT, 32'h0);
    rdc(`CC_OFF_CAUSE, 32'h0);
    cmp(irq, 1'b0);
    tend("reset");
    wr(`CC_OFF_BITTIM, 32'hFFFF_FFFF);
    rdc(`CC_OFF_BITTIM, `CC_BT_MASK);
    wr(`CC_OFF_BITTIM, 32'h0002_1402);
    rdc(`CC_OFF_BITTIM, 32'h0002_1402);
    cmp(sync_jump_width, 2'h2);
    // an unreachable rate writes nothing, so the old timing must stay
    rdc(`CC_OFF_BITTIM, 32'h0002_1402);
    tend("timing fields");
    // every object written with a known value before the first enable
    for (int i = 0; i < 32; i++) begin
      wr(`CC_OFF_OBJSEL, i);
      wr(`CC_OFF_OBJDATA, 32'hC0DE_0000 | i);
    end
    wr(`CC_OFF_TXREQ, 32'h0000_000A);
    u_cc_eng_model.rx_frame(5'h05, 32'h1234_5678);
    seen = 1'b0;
    repeat (20) begin
      @(posedge pclk);
      seen = seen | (tx_req_valid === 1'b1);
    end
    cmp(seen, 1'b0);
    rdc(`CC_OFF_PEND, 32'h0);
    wr(`CC_OFF_INTEN, 32'h3);
    wr(`CC_OFF_CTL, 32'h1);
    wait_tx(2);
    cmp(u_cc_eng_model.tx_obj[0], 5'h01);
    cmp(u_cc_eng_model.tx_obj[1], 5'h03);
    cmp(u_cc_eng_model.tx_dat[1], 32'hC0DE_0003);
    rdc(`CC_OFF_TXREQ, 32'h0);
    rdc(`CC_OFF_STATUS, 32'h5);
    rdc(`CC_OFF_PEND, 32'hA);
    rdc(`CC_OFF_CAUSE, 32'h2);
    cmp(irq, 1'b1);
    tend("enable and send");
    wr(`CC_OFF_INTCLR, 32'd33);
    rdc(`CC_OFF_PEND, 32'hA);
    wr(`CC_OFF_INTCLR, 32'h2);
    rdc(`CC_OFF_PEND, 32'h8);
    rdc(`CC_OFF_CAUSE, 32'h4);
    wr(`CC_OFF_OBJSEL, 32'h3);
    rdc(`CC_OFF_OBJDATA, 32'hC0DE_0003);
    rdc(`CC_OFF_PEND, 32'h0);
    cmp(irq, 1'b0);
    tend("clears");
    u_cc_eng_model.rx_frame(5'h05, 32'h1234_5678);
    rdc(`CC_OFF_STATUS, 32'h9);
    rdc(`CC_OFF_CAUSE, 32'h6);
    wr(`CC_OFF_OBJSEL, 32'h5);
    rdc(`CC_OFF_OBJDATA, 32'h1234_5678);
    rdc(`CC_OFF_PEND, 32'h0);
    tend("receive");
    u_cc_eng_model.errs(127, 2);
    rdc(`CC_OFF_ERRCNT, 32'h0000_7F10);
    rdc(`CC_OFF_CAUSE, `CC_STATUS_CODE);
    cmp(irq, 1'b1);
    u_cc_eng_model.errs(1, 0);
    rdc(`CC_OFF_ERRCNT, 32'h0001_8010);
    rdc(`CC_OFF_STATUS, 32'h13);
    rdc(`CC_OFF_CAUSE, 32'h0);
    u_cc_eng_model.errs(0, 1);
    rdc(`CC_OFF_CAUSE, `CC_STATUS_CODE);
    // status source masked: pending status alone must not raise irq
    wr(`CC_OFF_INTEN, 32'h1);
    rdc(`CC_OFF_INTEN, 32'h1);
    cmp(irq, 1'b0);
    wr(`CC_OFF_INTEN, 32'h3);
    wr(`CC_OFF_INTCLR, `CC_STATUS_CODE);
    rdc(`CC_OFF_CAUSE, 32'h0);
    tend("errors");
    tmeas(32'h0002_1402, 1'b0, 10, 12, 6);
    tmeas(32'h0000_0101, 1'b1, 2, 3, 3);
    tend("bit timing");
    wr(`CC_OFF_CTL, 32'h0);
    // enable falls at the write's own edge; look one edge later
    @(posedge pclk);
    cmp(bus_active, 1'b0);
    rdc(`CC_OFF_BITTIM, 32'h0000_0101);
    rdc(`CC_OFF_ERRCNT, 32'h0001_8018);
    wr(`CC_OFF_OBJSEL, 32'h7);
    rdc(`CC_OFF_OBJDATA, 32'hC0DE_0007);
    apb(1'b0, 8'h40, 32'h0);
    cmp(er, 1'b1);
    cmp(rd, 32'h0);
    wr(`CC_OFF_TXREQ, 32'h1);
    repeat (10) @(posedge pclk);
    cmp(u_cc_eng_model.tx_cnt, 2);
    wr(`CC_OFF_CTL, 32'h1);
    wait_tx(3);
    cmp(u_cc_eng_model.tx_obj[2], 5'h00);
    tend("disable");
    test_done;
  end
endmodule : can_controller_timing_and_control_bench
`default_nettype wire

/* dv/cc_eng_model.sv */
`default_nettype none
module cc_eng_model (
  // clock
  input  wire logic        pclk,
  // frame offers from the controller
  input  wire logic        tx_req_valid,
  input  wire logic [4:0]  tx_req_obj,
  input  wire logic [31:0] tx_req_data,
  // bus events back to the controller
  output logic             eng_tx_done,
  output logic             eng_tx_err,
  output logic             eng_rx_valid,
  output logic [4:0]       eng_rx_obj,
  output logic [31:0]      eng_rx_data,
  output logic             eng_rx_err
);
  timeunit 1ns;
  timeprecision 1ps;
  int          tx_cnt = 0;
  logic [4:0]  tx_obj [8];
  logic [31:0] tx_dat [8];

  // idle levels at time zero
  initial begin
    {eng_tx_done, eng_tx_err, eng_rx_valid, eng_rx_err} = 4'h0;
    eng_rx_obj = 5'h00;
    eng_rx_data = 32'h0;
  end

  // ack each offered frame, every other one slowly as a busy bus would
  always begin
    @(posedge pclk);
    if (tx_req_valid === 1'b1) begin
      repeat (tx_cnt % 2 ? 0 : 4) @(posedge pclk);
      // offer may vanish during the wait, e.g. on disable
      if (tx_req_valid === 1'b1) begin
        tx_obj[tx_cnt % 8] = tx_req_obj;
        tx_dat[tx_cnt % 8] = tx_req_data;
        eng_tx_done <= 1'b1;
        @(posedge pclk);
        eng_tx_done <= 1'b0;
        tx_cnt++;
        @(posedge pclk);
      end
    end
  end

  // one frame; lines then show the inverse, never a held copy
  task automatic rx_frame(input logic [4:0] obj, input logic [31:0] data);
    @(posedge pclk);
    eng_rx_valid <= 1'b1;
    eng_rx_obj <= obj;
    eng_rx_data <= data;
    @(posedge pclk);
    eng_rx_valid <= 1'b0;
    eng_rx_obj <= ~obj;
    eng_rx_data <= ~data;
  endtask : rx_frame

  // error bursts, rx and tx errors pulsing together every other cycle
  task automatic errs(input int nrx, input int ntx);
    for (int i = 0; i < (nrx > ntx ? nrx : ntx); i++) begin
      @(posedge pclk);
      eng_rx_err <= (i < nrx);
      eng_tx_err <= (i < ntx);
      @(posedge pclk);
      eng_rx_err <= 1'b0;
      eng_tx_err <= 1'b0;
    end
  endtask : errs
endmodule : cc_eng_model
`default_nettype wire
